// [verilog/bcdr_pkg.sv]
// Package holding register map, field layout and timing constants.
package bcdr_pkg;
	localparam logic [7:0]  DIAG0_OFFSET     = 8'hc0;
	localparam logic [7:0]  DIAG1_OFFSET     = 8'hc4;
	localparam logic [31:0] DIAG0_RESET      = 32'h0000_0000;
	localparam logic [31:0] DIAG1_RESET      = 32'h0012_0108;
	// Register 0 field positions.
	localparam int          D0_THR_VAL_LSB   = 4;
	localparam int          D0_THR_EN_BIT    = 3;
	localparam int          D0_CFG_MEM_BIT   = 2;
	localparam int          D0_RSVD_RW_BIT   = 1;
	// Register 1 field positions.
	localparam int          D1_SEP_LAT_LSB   = 18;
	localparam int          D1_SHR_LAT_LSB   = 15;
	localparam int          D1_RSVD_HI_LSB   = 11;
	localparam int          D1_SUPPRESS_BIT  = 10;
	localparam int          D1_L1_DELAY_LSB  = 6;
	localparam int          D1_L0S_DELAY_LSB = 2;
	localparam int          D1_RSVD_LO_LSB   = 0;
	// Writable masks; all other bits read as zero.
	localparam logic [31:0] DIAG0_WMASK      = 32'h0000_003e;
	localparam logic [31:0] DIAG1_WMASK      = 32'h001f_ffff;
	// Threshold arithmetic, in doublewords.
	localparam logic [9:0]  DEFAULT_LINE_DW  = 10'h008;
	localparam logic [9:0]  THR_ADD_4DW      = 10'h004;
	localparam logic [9:0]  THR_ADD_8DW      = 10'h008;
	localparam logic [9:0]  THR_ADD_12DW     = 10'h00c;
	// Timer ticks converted to 100 ns clock cycles.
	localparam int          CLK_PERIOD_PS    = 100000;
	localparam int          L1_TICK_PS       = 512000;
	localparam int          L0S_TICK_PS      = 16000;
	localparam int          L1_TICK_CYC_I    =
		(L1_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          L0S_TICK_CYC_I   =
		((L0S_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
		((L0S_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0]  L1_TICK_CYC      = 4'(L1_TICK_CYC_I);
	localparam logic [3:0]  L0S_TICK_CYC     = 4'(L0S_TICK_CYC_I);

	typedef enum logic [1:0] {
		BCDR_THR_PLUS4  = 2'b00,
		BCDR_THR_PLUS8  = 2'b01,
		BCDR_THR_PLUS12 = 2'b10,
		BCDR_THR_TWO4   = 2'b11
	} bcdr_thr_code_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} bcdr_cfg_req_t;
endpackage

// [verilog/bcdr_regs.sv]
// Control and diagnostic registers 0 and 1 with their consumers.
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Threshold code adds 4, 8 or 12 DW to a line, or two lines plus 4.
// [RULE2] An invalid cache line size counts as an 8 DW line.
// [RULE3] Threshold control bit set enables threshold mode; clear by default.
// [RULE4] Config access bit lets config cycles reach memory-mapped registers.
// [RULE5] Register 0 bit 1 is writable reserved, resets 0; software writes 0.
// [RULE6] Register 0 bit 0 and register 1 bits 31:21 read as zero.
// [RULE7] Register 1 bits 14:11 and 1:0 are writable reserved, written zero.
// [RULE8] Separate-clock Advertised_a, default 100b, shown when clock shared.
// [RULE9] Shared-clock Advertised_a, default 100b, shown when clock not shared.
// [RULE10] Suppress bit masks the secondary bus reset; defaults to 0.
// [RULE11] L1 entry delay field counts 512 ns ticks; default 0100b. Code counts 600 ns ticks (6 cycles).
// [RULE12] L0s entry delay field counts 62.5 MHz ticks; default 0010b. Code counts one 100 ns cycle per tick.
// [RULE13] Software should leave register 1 at defaults.
// [RULE14] Fields reset on link reset, global reset or power-on reset.
// [RULE15] Timers restart on activity; request follows expiry while idle.
module bcdr_regs
	import bcdr_pkg::*;
(
	input  wire logic          i_clock,
	input  wire logic          i_sys_rst,
	input  wire logic          i_link_reset_pin,
	input  wire logic          i_global_reset_pin,
	input  wire bcdr_cfg_req_t i_cfg_req,
	input  wire logic          i_shared_clock_config,
	input  wire logic          i_secondary_bus_reset_bit,
	input  wire logic [7:0]    i_cache_line_size,
	input  wire logic          i_link_idle,
	output logic [31:0]        o_cfg_rdata,
	output logic               o_cfg_ack,
	output logic               o_up_buf_thr_en,
	output logic [9:0]         o_up_buf_thr_dw,
	output logic               o_cfg_mem_access_en,
	output logic [2:0]         o_advertised_a,
	output logic               o_secondary_reset,
	output logic               o_l0s_entry_req,
	output logic               o_l1_entry_req
);
	logic [31:0] diag0_r;
	logic [31:0] diag1_r;
	logic [31:0] bemask;
	logic        field_rst;
	logic        line_ok;
	logic [9:0]  line_dw;
	logic [9:0]  thr_nxt;
	logic [31:0] diag0_nxt;
	logic [31:0] diag1_nxt;
	logic [31:0] rdata_nxt;
	logic        wr0_hit;
	logic        wr1_hit;
	logic        rd0_hit;
	logic        rd1_hit;
	logic [7:0]  tmr_cnt_r [2];
	logic [7:0]  tmr_target [2];
	logic        tmr_req_r [2];

	assign field_rst = i_link_reset_pin | i_global_reset_pin; // [RULE14]

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_be
			assign bemask[g*8 +: 8] = {8{i_cfg_req.be[g]}};
		end
	endgenerate

	assign wr0_hit = i_cfg_req.wr && (i_cfg_req.addr == DIAG0_OFFSET);
	assign wr1_hit = i_cfg_req.wr && (i_cfg_req.addr == DIAG1_OFFSET);
	assign rd0_hit = i_cfg_req.rd && (i_cfg_req.addr == DIAG0_OFFSET);
	assign rd1_hit = i_cfg_req.rd && (i_cfg_req.addr == DIAG1_OFFSET);

	// Only writable bits are stored; the masks keep read-only bits at zero.
	always_comb begin
		diag0_nxt = diag0_r;
		if (wr0_hit) begin
			diag0_nxt = (diag0_r & ~(bemask & DIAG0_WMASK)) |
				(i_cfg_req.wdata & bemask & DIAG0_WMASK); // [RULE6]
		end
	end

	always_comb begin
		diag1_nxt = diag1_r;
		if (wr1_hit) begin
			diag1_nxt = (diag1_r & ~(bemask & DIAG1_WMASK)) |
				(i_cfg_req.wdata & bemask & DIAG1_WMASK); // [RULE6] [RULE7]
		end
	end

	// Link and global reset override a write in the same cycle.
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			diag0_r <= DIAG0_RESET;
		end else if (field_rst) begin
			diag0_r <= DIAG0_RESET; // [RULE14]
		end else begin
			diag0_r <= diag0_nxt;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			diag1_r <= DIAG1_RESET;
		end else if (field_rst) begin
			diag1_r <= DIAG1_RESET; // [RULE14]
		end else begin
			diag1_r <= diag1_nxt;
		end
	end

	// Unmapped offsets read as zero.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (rd0_hit) begin
			rdata_nxt = diag0_r & DIAG0_WMASK; // [RULE6]
		end else if (rd1_hit) begin
			rdata_nxt = diag1_r & DIAG1_WMASK; // [RULE6]
		end
	end

	// Reads and writes both answer one cycle after the request.
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cfg_rdata <= 32'h0000_0000;
			o_cfg_ack   <= 1'b0;
		end else begin
			o_cfg_ack   <= i_cfg_req.rd | i_cfg_req.wr;
			o_cfg_rdata <= rdata_nxt;
		end
	end

	// A cache line size is valid when it is a nonzero power of two.
	assign line_ok = (i_cache_line_size != 8'h00) &&
		((i_cache_line_size & (i_cache_line_size - 8'h01)) == 8'h00);
	assign line_dw = line_ok ? {2'b00, i_cache_line_size}
		: DEFAULT_LINE_DW; // [RULE2]

	always_comb begin
		case (bcdr_thr_code_t'(diag0_r[D0_THR_VAL_LSB +: 2]))
			BCDR_THR_PLUS4:  thr_nxt = line_dw + THR_ADD_4DW; // [RULE1]
			BCDR_THR_PLUS8:  thr_nxt = line_dw + THR_ADD_8DW; // [RULE1]
			BCDR_THR_PLUS12: thr_nxt = line_dw + THR_ADD_12DW; // [RULE1]
			BCDR_THR_TWO4:   thr_nxt = line_dw + line_dw + THR_ADD_4DW; // [RULE1]
			default:         thr_nxt = line_dw + THR_ADD_4DW;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_up_buf_thr_en <= 1'b0;
		end else begin
			o_up_buf_thr_en <= diag0_r[D0_THR_EN_BIT]; // [RULE3]
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_up_buf_thr_dw <= 10'h000;
		end else begin
			o_up_buf_thr_dw <= thr_nxt; // [RULE1]
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cfg_mem_access_en <= 1'b0;
		end else begin
			o_cfg_mem_access_en <= diag0_r[D0_CFG_MEM_BIT]; // [RULE4]
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_advertised_a <= 3'h0;
		end else begin
			o_advertised_a <= i_shared_clock_config
				? diag1_r[D1_SEP_LAT_LSB +: 3] // [RULE8]
				: diag1_r[D1_SHR_LAT_LSB +: 3]; // [RULE9]
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_secondary_reset <= 1'b0;
		end else begin
			o_secondary_reset <= i_secondary_bus_reset_bit &
				~diag1_r[D1_SUPPRESS_BIT]; // [RULE10]
		end
	end

	// Entry 0 is the L0s_entry_delay, entry 1 the L1 timer.
	genvar tm;
	generate
		for (tm = 0; tm < 2; tm++) begin : g_tmr
			logic [3:0] delay_field;
			logic [3:0] tick_cyc;
			assign delay_field = (tm == 0) ? diag1_r[D1_L0S_DELAY_LSB +: 4]
				: diag1_r[D1_L1_DELAY_LSB +: 4]; // [RULE11] [RULE12]
			assign tick_cyc = (tm == 0) ? L0S_TICK_CYC : L1_TICK_CYC;
			assign tmr_target[tm] = {4'h0, delay_field} * {4'h0, tick_cyc};

			// The count holds at zero while busy and stops at its target.
			always_ff @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					tmr_cnt_r[tm] <= 8'h00;
				end else if (!i_link_idle) begin
					tmr_cnt_r[tm] <= 8'h00; // [RULE15]
				end else if (tmr_cnt_r[tm] < tmr_target[tm]) begin
					tmr_cnt_r[tm] <= tmr_cnt_r[tm] + 8'h01; // [RULE11] [RULE12]
				end
			end

			// Entry is requested only once the idle count has expired.
			always_ff @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					tmr_req_r[tm] <= 1'b0;
				end else begin
					tmr_req_r[tm] <= i_link_idle &&
						(tmr_cnt_r[tm] >= tmr_target[tm]); // [RULE15]
				end
			end
		end
	endgenerate

	assign o_l0s_entry_req = tmr_req_r[0];
	assign o_l1_entry_req  = tmr_req_r[1];
endmodule // bcdr_regs

// [verification/bcdr_regs_asserts.sv]
// Checker for the diagnostic register block ports.
`timescale 1ns/100ps
module bcdr_regs_chk
	import bcdr_pkg::*;
(
	input wire logic          i_clock,
	input wire logic          i_sys_rst,
	input wire logic          i_link_reset_pin,
	input wire logic          i_global_reset_pin,
	input wire bcdr_cfg_req_t i_cfg_req,
	input wire logic          i_secondary_bus_reset_bit,
	input wire logic          i_link_idle,
	input wire logic [31:0]   o_cfg_rdata,
	input wire logic          o_cfg_ack,
	input wire logic [2:0]    o_advertised_a,
	input wire logic          o_secondary_reset,
	input wire logic          o_l0s_entry_req,
	input wire logic          o_l1_entry_req
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence s_rst;
		i_link_reset_pin || i_global_reset_pin;
	endsequence
	sequence s_rd1;
		i_cfg_req.rd && i_cfg_req.addr == DIAG1_OFFSET;
	endsequence
	sequence s_rd0;
		i_cfg_req.rd && i_cfg_req.addr == DIAG0_OFFSET;
	endsequence
	a_reg1_hi_zero: assert property (
		s_rd1 |=> o_cfg_ack && o_cfg_rdata[31:21] == 11'h000)
		else $error("Register 1 reserved bits read nonzero.");
	a_reg0_rsvd_zero: assert property (
		s_rd0 |=> o_cfg_ack && o_cfg_rdata[0] == 1'b0)
		else $error("Register 0 bit 0 read nonzero.");
	a_reset_read_dflt: assert property (
		s_rst ##1 s_rd1 |=> o_cfg_rdata == DIAG1_RESET)
		else $error("Register 1 not back at default after reset.");
	a_reset_lat_dflt: assert property (
		s_rst |=> ##1 o_advertised_a == 3'h4)
		else $error("Advertised latency not default after reset.");
	a_reset_mask_dflt: assert property (
		s_rst |=> ##1 o_secondary_reset == $past(i_secondary_bus_reset_bit))
		else $error("Reset suppress not cleared by reset.");
	a_sec_rst_gated: assert property (
		!i_secondary_bus_reset_bit |=> !o_secondary_reset)
		else $error("Secondary reset without its control bit.");
	a_l0s_idle_drop: assert property (
		!i_link_idle |=> !o_l0s_entry_req)
		else $error("L0s request while link busy.");
	a_l1_idle_drop: assert property (
		!i_link_idle |=> !o_l1_entry_req)
		else $error("L1 request while link busy.");
endmodule // bcdr_regs_chk
bind bcdr_regs bcdr_regs_chk u_bcdr_regs_chk (.*);

// [verification/bcdr_regs_test.sv]
// Self-checking bench for the diagnostic register block.
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
	$display("FAIL %s exp %h got %h", n, e, s); end end
module bcdr_regs_test import bcdr_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] d; logic c; logic [31:0] r;
		logic [2:0] v; logic [9:0] t; logic [1:0] e;} bcdr_row_t;
	logic i_clock = 0, i_sys_rst = 1, i_link_reset_pin = 0, i_link_idle = 0;
	logic i_global_reset_pin = 0, i_shared_clock_config = 0;
	logic i_secondary_bus_reset_bit = 0, o_cfg_ack, o_up_buf_thr_en;
	logic o_cfg_mem_access_en, o_secondary_reset, o_l0s_entry_req;
	logic o_l1_entry_req;
	logic [7:0] i_cache_line_size = 8'h10;
	logic [31:0] o_cfg_rdata, rdv;
	logic [9:0] o_up_buf_thr_dw, b;
	logic [2:0] o_advertised_a;
	bcdr_cfg_req_t i_cfg_req = '0;
	int errors = 0, compares = 0, k, m;
	logic [7:0] lines[3] = '{8'h10, 8'h00, 8'h0c};
	bcdr_row_t rows[6] = '{
		'{8'hc4, 32'h0018_8108, 1, 32'h0018_8108, 3'h6, 10'h014, 2'h0},
		'{8'hc4, 32'h0018_8108, 0, 32'h0018_8108, 3'h1, 10'h014, 2'h0},
		'{8'hc4, 32'hffff_87fc, 0, 32'h001f_87fc, 3'h7, 10'h014, 2'h0},
		'{8'hc0, 32'hffff_fffd, 0, 32'h0000_003c, 3'h7, 10'h024, 2'h3},
		'{8'hc8, 32'hffff_ffff, 1, 32'h0000_0000, 3'h7, 10'h024, 2'h3},
		'{8'hc4, 32'h0012_0108, 1, 32'h0012_0108, 3'h4, 10'h024, 2'h3}};
	bcdr_regs u_bcdr_regs (.*);
	always #50 i_clock = ~i_clock;
	task print_verdict();
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_cfg_req = '{w, !w, a, 4'hf, d};
		@(negedge i_clock);
		`CHK("ack", 1'b1, o_cfg_ack)
		rdv = o_cfg_rdata;
		i_cfg_req = '0;
		@(negedge i_clock);
	endtask
	// Counts cycles from idle until each entry request rises.
	task tmr();
		int n, p, q;
		p = 0;
		q = 0;
		i_link_idle = 1;
		for (n = 1; n < 40; n++) begin
			@(negedge i_clock);
			if (o_l0s_entry_req === 1'b1 && p == 0) p = n;
			if (o_l1_entry_req === 1'b1 && q == 0) q = n;
		end
		`CHK("l0s_wait", 3, p)
		`CHK("l1_wait", 25, q)
		i_link_idle = 0;
		@(negedge i_clock);
	endtask
	initial begin
		#300000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (5) @(negedge i_clock);
		i_sys_rst = 0;
		cfg(0, DIAG0_OFFSET, 0);
		`CHK("reg0_dflt", DIAG0_RESET, rdv)
		foreach (rows[i]) begin
			cfg(1, rows[i].a, rows[i].d);
			i_shared_clock_config = rows[i].c;
			cfg(0, rows[i].a, 0);
			`CHK("rdata", rows[i].r, rdv)
			repeat (3) @(negedge i_clock);
			`CHK("latency", rows[i].v, o_advertised_a)
			`CHK("thr", rows[i].t, o_up_buf_thr_dw)
			`CHK("thr_en", rows[i].e[1], o_up_buf_thr_en)
			`CHK("mem_en", rows[i].e[0], o_cfg_mem_access_en)
		end
		for (k = 0; k < 12; k++) begin
			m = k % 3;
			cfg(1, DIAG0_OFFSET, 32'(k / 3) << 4);
			i_cache_line_size = lines[m];
			b = m == 0 ? 10'h010 : DEFAULT_LINE_DW;
			b = k / 3 == 3 ? 2 * b + 10'h004 : b + 10'(4 * (k / 3 + 1));
			repeat (3) @(negedge i_clock);
			`CHK("thr_code", b, o_up_buf_thr_dw)
			`CHK("thr_off", 1'b0, o_up_buf_thr_en)
		end
		i_secondary_bus_reset_bit = 1;
		for (k = 0; k < 2; k++) begin
			cfg(1, DIAG1_OFFSET, 32'h0012_0508);
			repeat (3) @(negedge i_clock);
			`CHK("sec_rst_mask", 1'b0, o_secondary_reset)
			{i_global_reset_pin, i_link_reset_pin} = k ? 2'h2 : 2'h1;
			@(negedge i_clock);
			{i_global_reset_pin, i_link_reset_pin} = 2'h0;
			cfg(0, DIAG1_OFFSET, 0);
			`CHK("reg1_dflt", DIAG1_RESET, rdv)
			repeat (3) @(negedge i_clock);
			`CHK("sec_rst_pass", 1'b1, o_secondary_reset)
		end
		tmr();
		i_link_idle = 1;
		repeat (20) @(negedge i_clock);
		i_link_idle = 0;
		@(negedge i_clock);
		tmr();
		print_verdict();
	end
endmodule // bcdr_regs_test
